// File: src/tcrf_pkg.sv
// Constants for the temperature conversion and result FIFO block
package tcrf_pkg;
  // Register offsets
  localparam logic [7:0] OFS_STATUS     = 8'h00;
  localparam logic [7:0] OFS_INT_EN     = 8'h01;
  localparam logic [7:0] OFS_FIFO_DATA  = 8'h08;
  localparam logic [7:0] OFS_FIFO_CNT   = 8'h09;
  localparam logic [7:0] OFS_UPPER_MSB  = 8'h10;
  localparam logic [7:0] OFS_UPPER_LSB  = 8'h11;
  localparam logic [7:0] OFS_LOWER_MSB  = 8'h12;
  localparam logic [7:0] OFS_LOWER_LSB  = 8'h13;
  localparam logic [7:0] OFS_SETUP      = 8'h14;
  localparam logic [7:0] OFS_PIN_SETUP  = 8'h20;
  localparam logic [7:0] OFS_PIN_LEVEL  = 8'h21;
  localparam logic [7:0] OFS_SERIAL0    = 8'h30;
  // Field positions
  localparam int STAT_LOW_BIT   = 0;
  localparam int STAT_HIGH_BIT  = 1;
  localparam int SETUP_CONV_BIT = 0;
  localparam int SETUP_RES_LSB  = 2;
  // Reset values and pin mode codes
  localparam logic [15:0] UPPER_RESET = 16'h7FFF;
  localparam logic [15:0] LOWER_RESET = 16'h8000;
  localparam logic [7:0]  SETUP_RESET = 8'hC0;
  localparam logic [5:0]  PIN_SETUP_RESET = 6'h2A;
  localparam logic [1:0]  PIN_MODE_SPECIAL = 2'h3;
  localparam logic [1:0]  PIN_MODE_OUTPUT  = 2'h1;
  // Timing
  localparam int CLK_NS = 10;
  localparam int PRESENCE_PWRUP_US = 2000;
  localparam int PRESENCE_PWRUP_CYC = PRESENCE_PWRUP_US * 1000 / CLK_NS;
  localparam int RESET_LOW_US = 480;
  localparam int RESET_LOW_CYC = (RESET_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PDH_US = 15;
  localparam int PDH_CYC = (PDH_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PDL_US = 60;
  localparam int PDL_CYC = (PDL_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CONV_US = 16500;
  localparam int CONV_CYC = CONV_US * 1000 / CLK_NS;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_CONVERT = 2'b01
  } tcrf_conv_t;

  typedef enum logic [1:0] {
    PR_IDLE  = 2'b00,
    PR_LOW   = 2'b01,
    PR_WAIT  = 2'b10,
    PR_PULSE = 2'b11
  } tcrf_pres_t;
endpackage

// File: src/tcrf_top.sv
// Conversion control, result FIFO, thresholds and presence for the sensor
`timescale 1ns/10ps
module tcrf_top
  import tcrf_pkg::*;
#(
  parameter int          DEPTH        = 32,
  parameter int          CONV_CYCLES  = CONV_CYC,
  parameter int          PWRUP_CYCLES = PRESENCE_PWRUP_CYC,
  parameter logic [63:0] SERIAL_CODE  = 64'h0123456789ABCDEF // Arbitrary
) (
  input  wire logic        SYS_CLK,     // System clock
  input  wire logic        RST,         // Async reset, high
  input  wire logic        REG_WR,      // Register write strobe
  input  wire logic        REG_RD,      // Register read strobe
  input  wire logic [7:0]  REG_ADDR,    // Register offset
  input  wire logic [7:0]  REG_WDATA,   // Write data
  output logic      [7:0]  REG_RDATA,   // Read data
  output logic             REG_RVALID,  // Read data valid
  input  wire logic [15:0] SENSE_CODE,  // Raw 16-bit sample from sensor
  input  wire logic        DQ_I,        // Data line level
  output logic             DQ_O,        // Data line drive value
  output logic             DQ_OE,       // Data line pull low
  input  wire logic [2:0]  GP_I,        // General pin levels
  output logic      [2:0]  GP_O,        // General pin drive values
  output logic      [2:0]  GP_OE,       // General pin enables
  output logic             BUSY         // Conversion running
);

  localparam int CW = $clog2(DEPTH);
  localparam int CC = $clog2(CONV_CYCLES + 1);
  localparam int PC = $clog2(PWRUP_CYCLES + RESET_LOW_CYC + 1);

  tcrf_conv_t       conv_q;
  logic [CC-1:0]    conv_cnt_q;
  logic [15:0]      upper_q, lower_q;
  logic [7:0]       setup_q, int_en_q;
  logic [5:0]       pin_setup_q;
  logic [2:0]       pin_out_q;
  logic [1:0]       status_q;
  logic [15:0]      fifo_q [DEPTH];
  logic [CW-1:0]    wr_ptr_q, rd_ptr_q;
  logic [CW:0]      count_q;
  logic [15:0]      last_q, result;
  logic             rd_lsb_q;
  logic             conv_start, conv_done, fifo_pop, ext_trig;
  tcrf_pres_t       pres_q;
  logic [PC-1:0]    pres_cnt_q;

  function automatic logic [15:0] quantise(input logic [15:0] raw,
                                           input logic [1:0]  res);
    logic [15:0] mask;
    mask = 16'hFFFF << (2'h3 - res);
    return raw & mask;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Conversion control
  assign ext_trig = (pin_setup_q[3:2] == PIN_MODE_SPECIAL) && !GP_I[1];
  assign conv_start = (REG_WR && REG_ADDR == OFS_SETUP
                       && REG_WDATA[SETUP_CONV_BIT]) || ext_trig;
  assign conv_done = (conv_q == ST_CONVERT) && (conv_cnt_q == '0);
  // Keep only the chosen resolution, sign bit kept, left-justified
  assign result = quantise(SENSE_CODE,
                           setup_q[SETUP_RES_LSB +: 2]);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      conv_q     <= ST_STANDBY;
      conv_cnt_q <= '0;
    end else begin
      case (conv_q)
        ST_STANDBY: begin
          if (conv_start) begin
            conv_q     <= ST_CONVERT;
            conv_cnt_q <= CC'(CONV_CYCLES - 1);
          end
        end
        ST_CONVERT: begin
          // New triggers are ignored here
          if (conv_cnt_q == '0) begin
            conv_q <= ST_STANDBY;
          end else begin
            conv_cnt_q <= conv_cnt_q - 1'b1;
          end
        end
        default: conv_q <= ST_STANDBY;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) BUSY <= 1'b0;
    else BUSY <= (conv_q == ST_CONVERT && !conv_done)
                 || (conv_q == ST_STANDBY && conv_start);
  end

  a_conv_ignore: assert property (@(posedge SYS_CLK) disable iff (RST)
    conv_q == ST_CONVERT && conv_cnt_q != '0 |=>
      conv_q == ST_CONVERT && conv_cnt_q == $past(conv_cnt_q) - 1'b1)
    else $error("Conversion restarted or stalled");
  a_conv_start: assert property (@(posedge SYS_CLK) disable iff (RST)
    conv_q == ST_STANDBY && ext_trig |=> conv_q == ST_CONVERT)
    else $error("Pin trigger did not start conversion");

  //////////////////////////////////////////////////////////////////////////
  // Result FIFO
  assign fifo_pop = REG_RD && REG_ADDR == OFS_FIFO_DATA && rd_lsb_q;

  always_ff @(posedge SYS_CLK) begin
    if (conv_done) fifo_q[wr_ptr_q] <= result;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      last_q   <= '0;
    end else begin
      if (conv_done) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
        last_q   <= result;
      end
      if (conv_done && count_q == (CW+1)'(DEPTH)) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end else if (conv_done && !(fifo_pop && count_q != '0)) begin
        count_q <= count_q + 1'b1;
      end else if (!conv_done && fifo_pop && count_q != '0) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        count_q  <= count_q - 1'b1;
      end else if (conv_done && fifo_pop && count_q != '0) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  a_fifo_bound: assert property (@(posedge SYS_CLK) disable iff (RST)
    count_q <= (CW+1)'(DEPTH))
    else $error("FIFO count exceeds depth");
  a_fifo_push: assert property (@(posedge SYS_CLK) disable iff (RST)
    conv_done && !fifo_pop && count_q < (CW+1)'(DEPTH) |=>
      count_q == $past(count_q) + 1'b1)
    else $error("Result not pushed");

  //////////////////////////////////////////////////////////////////////////
  // Registers and alarms
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      upper_q     <= UPPER_RESET;
      lower_q     <= LOWER_RESET;
      setup_q     <= SETUP_RESET;
      int_en_q    <= 8'h00;
      pin_setup_q <= PIN_SETUP_RESET;
      pin_out_q   <= 3'h0;
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_UPPER_MSB) upper_q[15:8] <= REG_WDATA;
      else if (REG_ADDR == OFS_UPPER_LSB) upper_q[7:0] <= REG_WDATA;
      else if (REG_ADDR == OFS_LOWER_MSB) lower_q[15:8] <= REG_WDATA;
      else if (REG_ADDR == OFS_LOWER_LSB) lower_q[7:0] <= REG_WDATA;
      else if (REG_ADDR == OFS_SETUP) setup_q <= {REG_WDATA[7:1], 1'b0};
      else if (REG_ADDR == OFS_INT_EN) int_en_q <= REG_WDATA;
      else if (REG_ADDR == OFS_PIN_SETUP) pin_setup_q <= REG_WDATA[5:0];
      else if (REG_ADDR == OFS_PIN_LEVEL) pin_out_q <= REG_WDATA[2:0];
    end
  end

  // Set wins over the clear by a status read
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) status_q <= 2'b00;
    else begin
      if (REG_RD && REG_ADDR == OFS_STATUS) status_q <= 2'b00;
      if (conv_done && $signed(result) < $signed(lower_q))
        status_q[STAT_LOW_BIT] <= 1'b1;
      if (conv_done && $signed(result) > $signed(upper_q))
        status_q[STAT_HIGH_BIT] <= 1'b1;
    end
  end

  a_alarm_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
    status_q[STAT_HIGH_BIT] && !(REG_RD && REG_ADDR == OFS_STATUS)
      |=> status_q[STAT_HIGH_BIT])
    else $error("High alarm dropped without status read");
  a_alarm_low: assert property (@(posedge SYS_CLK) disable iff (RST)
    conv_done && $signed(result) < $signed(lower_q)
      |=> status_q[STAT_LOW_BIT])
    else $error("Low alarm not set");

  //////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
      rd_lsb_q   <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      REG_RDATA  <= 8'h00;
      if (REG_RD && REG_ADDR == OFS_FIFO_DATA) rd_lsb_q <= !rd_lsb_q;
      if (REG_RD) begin
        if (REG_ADDR == OFS_STATUS) REG_RDATA <= {6'h00, status_q};
        else if (REG_ADDR == OFS_INT_EN) REG_RDATA <= int_en_q;
        else if (REG_ADDR == OFS_FIFO_DATA) begin
          if (count_q == '0)
            REG_RDATA <= rd_lsb_q ? last_q[7:0] : last_q[15:8];
          else
            REG_RDATA <= rd_lsb_q ? fifo_q[rd_ptr_q][7:0]
                                  : fifo_q[rd_ptr_q][15:8];
        end
        else if (REG_ADDR == OFS_FIFO_CNT) REG_RDATA <= 8'(count_q);
        else if (REG_ADDR == OFS_UPPER_MSB) REG_RDATA <= upper_q[15:8];
        else if (REG_ADDR == OFS_UPPER_LSB) REG_RDATA <= upper_q[7:0];
        else if (REG_ADDR == OFS_LOWER_MSB) REG_RDATA <= lower_q[15:8];
        else if (REG_ADDR == OFS_LOWER_LSB) REG_RDATA <= lower_q[7:0];
        else if (REG_ADDR == OFS_SETUP)
          REG_RDATA <= {setup_q[7:1], conv_q == ST_CONVERT};
        else if (REG_ADDR == OFS_PIN_SETUP) REG_RDATA <= {2'h0, pin_setup_q};
        else if (REG_ADDR == OFS_PIN_LEVEL)
          REG_RDATA <= {5'h00, GP_I};
        else if (REG_ADDR[7:3] == OFS_SERIAL0[7:3])
          REG_RDATA <= SERIAL_CODE[REG_ADDR[2:0]*8 +: 8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // General pins; pin 0 carries the alarm interrupt in mode 11
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      GP_O  <= 3'h0;
      GP_OE <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        GP_O[i]  <= pin_out_q[i];
        GP_OE[i] <= pin_setup_q[2*i +: 2] == PIN_MODE_OUTPUT;
      end
      if (pin_setup_q[1:0] == PIN_MODE_SPECIAL) begin
        GP_O[0]  <= 1'b0;
        GP_OE[0] <= |(status_q & int_en_q[1:0]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Presence pulse on the data line
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pres_q     <= PR_PULSE;
      pres_cnt_q <= PC'(PDL_CYC);
    end else begin
      case (pres_q)
        PR_IDLE: begin
          pres_cnt_q <= DQ_I ? '0 : pres_cnt_q + 1'b1;
          if (!DQ_I && pres_cnt_q >= PC'(RESET_LOW_CYC - 1))
            pres_q <= PR_LOW;
        end
        PR_LOW: if (DQ_I) begin
          pres_q     <= PR_WAIT;
          pres_cnt_q <= PC'(PDH_CYC);
        end
        PR_WAIT: begin
          pres_cnt_q <= pres_cnt_q - 1'b1;
          if (pres_cnt_q == '0) begin
            pres_q     <= PR_PULSE;
            pres_cnt_q <= PC'(PDL_CYC);
          end
        end
        PR_PULSE: begin
          pres_cnt_q <= pres_cnt_q - 1'b1;
          // Restart the low-time count from zero, not from a wrapped value
          if (pres_cnt_q == '0) begin
            pres_q     <= PR_IDLE;
            pres_cnt_q <= '0;
          end
        end
        default: pres_q <= PR_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      DQ_O  <= 1'b0;
      DQ_OE <= 1'b0;
    end else begin
      DQ_O  <= 1'b0;
      DQ_OE <= pres_q == PR_PULSE && pres_cnt_q != '0;
    end
  end

  a_dq_never_high: assert property (@(posedge SYS_CLK) disable iff (RST)
    DQ_OE |-> !DQ_O)
    else $error("Data line driven high");
  a_pres_after: assert property (@(posedge SYS_CLK) disable iff (RST)
    pres_q == PR_WAIT && pres_cnt_q == '0 |=> ##1 DQ_OE)
    else $error("Presence pulse missing");

endmodule // tcrf_top

// File: dv/tcrf_master_model.sv
// Bus master model: reset pulse and presence sample on the data line
`timescale 1ns/10ps
module tcrf_master_model
  import tcrf_pkg::*;
(
  input  wire logic sys_clk, // System clock
  input  wire logic dev_oe,  // Device pulls line low
  output logic      dq_line  // Resolved line, pulled up
);
  logic pull_q = 1'b0;
  // Open drain on both sides, pull-up when released
  assign dq_line = !(pull_q || dev_oe);
  task automatic reset_pulse(output logic seen);
    pull_q = 1'b1;
    repeat (RESET_LOW_CYC) @(negedge sys_clk);
    pull_q = 1'b0;
    repeat (PDH_CYC + PDL_CYC / 2) @(negedge sys_clk);
    seen = dq_line;
    // Stay quiet for the rest of the reset-high time
    repeat (RESET_LOW_CYC - PDH_CYC - PDL_CYC / 2) @(negedge sys_clk);
  endtask
endmodule // tcrf_master_model

// File: dv/tcrf_top_bench.sv
// Self-checking bench for the conversion and result FIFO block
`timescale 1ns/10ps
module tcrf_top_bench;
  import tcrf_pkg::*;
  localparam logic [63:0] CODE = 64'h5A5A1234C3C30F0F; // Arbitrary
  typedef struct {logic [7:0] v; string n;} tcrfb_exp_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [15:0] sense = 16'h0000;
  logic [2:0]  gp_i = 3'b111;
  logic [7:0]  rdata;
  logic [2:0]  gp_o, gp_oe;
  logic        rvalid, dq_i, dq_o, dq_oe, busy, seen;
  logic [15:0] c;
  int          n_errors = 0;
  int          cmp_count = 0;
  tcrfb_exp_t  q[$];
  tcrfb_exp_t  e;
  tcrf_top #(.CONV_CYCLES(50), .SERIAL_CODE(CODE)) u_dut (
    .SYS_CLK(clk), .RST(rst), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .SENSE_CODE(sense), .DQ_I(dq_i),
    .DQ_O(dq_o), .DQ_OE(dq_oe), .GP_I(gp_i), .GP_O(gp_o),
    .GP_OE(gp_oe), .BUSY(busy));
  tcrf_master_model u_m (.sys_clk(clk), .dev_oe(dq_oe), .dq_line(dq_i));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, x, input string n);
    cmp_count++;
    if (s !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    wr_s = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, x, input string n);
    @(negedge clk);
    q.push_back('{x, n});
    rd_s = 1'b1;
    addr = a;
    @(negedge clk);
    rd_s = 1'b0;
  endtask
  task automatic rw(input logic [15:0] x);
    rd(OFS_FIFO_DATA, x[15:8], "word msb");
    rd(OFS_FIFO_DATA, x[7:0], "word lsb");
  endtask
  task automatic wt();
    @(negedge clk);
    chk(busy, 1'b1, "busy");
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
    chk(busy, 1'b0, "back to standby");
  endtask
  task automatic cv(input logic [7:0] s, input logic [15:0] x);
    sense = x;
    wr(OFS_SETUP, s);
    wt();
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (q.size() > 0) begin
        e = q.pop_front();
        chk(rdata, e.v, e.n);
      end else chk(1'b1, 1'b0, "unrequested read");
    end
  end
  initial begin
    #1300us;
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h919E));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(dq_oe, 1'b1, "power-up presence");
    chk(dq_o, 1'b0, "line drive");
    chk(busy, 1'b0, "standby");
    rd(OFS_UPPER_MSB, 8'h7F, "upper msb");
    rd(OFS_UPPER_LSB, 8'hFF, "upper lsb");
    rd(OFS_LOWER_MSB, 8'h80, "lower msb");
    rd(OFS_LOWER_LSB, 8'h00, "lower lsb");
    // Dirty two threshold bytes, then reset again mid-run
    wr(OFS_LOWER_MSB, 8'hE0);
    wr(OFS_UPPER_LSB, 8'h88);
    rd(OFS_LOWER_MSB, 8'hE0, "lower written");
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(OFS_LOWER_MSB, 8'h80, "lower after reset");
    rd(OFS_UPPER_LSB, 8'hFF, "upper after reset");
    chk(dq_oe, 1'b1, "presence rearmed");
    rd(8'h7F, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) rd(OFS_SERIAL0 + 8'(i), CODE[8*i+:8], "serial");
    for (int r = 0; r < 4; r++) begin
      c = 16'($urandom);
      cv(8'h01 | 8'(r << 2), c);
      rw(c & (16'hFFFF << (3 - r)));
    end
    rd(OFS_STATUS, 8'h00, "no alarm at defaults");
    gp_i = 3'($urandom) & 3'b101;
    rd(OFS_PIN_LEVEL, {5'h00, gp_i}, "pin levels");
    chk(busy, 1'b0, "pin 1 not armed");
    wr(OFS_PIN_SETUP, 8'h15);
    wr(OFS_PIN_LEVEL, 8'h05);
    @(negedge clk);
    chk(gp_oe, 3'b111, "pin enables");
    chk(gp_o, 3'b101, "pin drives");
    gp_i = 3'b111;
    wr(OFS_PIN_SETUP, 8'h2E);
    sense = 16'hF060;
    gp_i = 3'b101;
    repeat (2) @(negedge clk);
    gp_i = 3'b111;
    wt();
    rw(16'hF060);
    wr(OFS_PIN_SETUP, 8'h2A);
    wr(OFS_UPPER_MSB, 8'h13);
    wr(OFS_UPPER_LSB, 8'h88);
    cv(8'h0D, 16'h2000);
    rw(16'h2000);
    cv(8'h0D, 16'h0000);
    rw(16'h0000);
    rd(OFS_STATUS, 8'h02, "high alarm held");
    rd(OFS_STATUS, 8'h00, "cleared by read");
    wr(OFS_LOWER_MSB, 8'hE0);
    wr(OFS_LOWER_LSB, 8'hC0);
    cv(8'h0D, 16'hE000);
    rw(16'hE000);
    wr(OFS_INT_EN, 8'h01);
    wr(OFS_PIN_SETUP, 8'h2B);
    @(negedge clk);
    chk(gp_oe, 3'b001, "alarm interrupt");
    rd(OFS_STATUS, 8'h01, "low alarm");
    @(negedge clk);
    chk(gp_oe, 3'b000, "interrupt cleared");
    sense = 16'h1388;
    wr(OFS_SETUP, 8'h0D);
    wr(OFS_SETUP, 8'h0D);
    wt();
    rd(OFS_FIFO_CNT, 8'h01, "one result");
    rw(16'h1388);
    for (int i = 0; i < 33; i++) cv(8'h0D, 16'(i));
    rd(OFS_FIFO_CNT, 8'h20, "fifo full");
    for (int i = 1; i < 33; i++) rw(16'(i));
    rw(16'd32);
    for (int i = 0; i < PDL_CYC && dq_oe === 1'b1; i++) @(negedge clk);
    chk(dq_oe, 1'b0, "presence over");
    u_m.reset_pulse(seen);
    chk(seen, 1'b0, "presence after reset");
    end_of_test();
  end
endmodule // tcrf_top_bench
